// File: src/dq_pkg.sv
// Package for the dynamic-Q inventory controller: constants and carriers
package dq_pkg;
	localparam int QW = 4;
	localparam int CW = 16;
	localparam logic [3:0] Q_START_RST = 4'h4;
	localparam logic [3:0] Q_MAX_RST = 4'hF;
	localparam logic [3:0] Q_MIN_RST = 4'h0;
	localparam logic [3:0] MULT_RST = 4'h1;
	localparam logic [15:0] REPS_RST = 16'h0010;
	localparam logic [3:0] HI_RST = 4'h2;
	localparam logic [3:0] LO_RST = 4'h1;
	// Register offsets (register port, 4-bit address)
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_QCFG = 4'h1;
	localparam logic [3:0] A_THR = 4'h2;
	localparam logic [3:0] A_REPS = 4'h3;
	localparam logic [3:0] A_STAT = 4'h4;
	localparam logic [3:0] A_RN16 = 4'h5;
	localparam logic [3:0] A_EPC = 4'h6;
	localparam logic [3:0] A_TAGS = 4'h7;
	// CTRL fields
	localparam int F_START = 0;
	localparam int F_MODE = 1;
	localparam int F_SESS = 4;
	// Modes
	localparam logic [1:0] M_DQ1 = 2'h1;
	localparam logic [1:0] M_DQ2 = 2'h2;
	localparam logic [1:0] M_DQ3 = 2'h3;
	// Air commands
	typedef enum logic [1:0] {
		CMD_QUERY = 2'h0,
		CMD_REP = 2'h1,
		CMD_ADJ = 2'h2
	} dq_cmd_t;
	typedef enum logic [1:0] {
		SLOT_EMPTY = 2'h0,
		SLOT_COLL = 2'h1,
		SLOT_READ = 2'h2
	} dq_res_t;
	typedef struct packed {
		logic valid;
		dq_cmd_t cmd;
		logic [3:0] q;
		logic [1:0] session;
		logic [2:0] updn;
	} dq_cmd_bus_t;
	typedef struct packed {
		logic valid;
		dq_res_t res;
	} dq_res_bus_t;
endpackage

// File: src/dq_cnt.sv
// Slot result counters: RN16 timeouts, EPC timeouts and tag reads
`timescale 1ns/1ps
`default_nettype none
module dq_cnt #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic valid,
	input wire dq_pkg::dq_res_t res,
	// Counts
	output logic [W-1:0] rn16_cnt,
	output logic [W-1:0] epc_cnt,
	output logic [W-1:0] tag_cnt
);
	typedef struct packed {
		logic [W-1:0] rn;
		logic [W-1:0] epc;
		logic [W-1:0] tag;
	} dq_cnt_st_t;
	dq_cnt_st_t s_reg, s_next;

	// Saturating increment keeps a long round from wrapping
	function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v);
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction

	// Count each slot result; clear wins for a fresh evaluation window
	always_comb begin
		s_next = s_reg;
		if (clear) begin
			s_next = '0;
		end else if (valid) begin
			unique case (res)
				dq_pkg::SLOT_EMPTY: s_next.rn = sat_inc(s_reg.rn);
				dq_pkg::SLOT_COLL: s_next.epc = sat_inc(s_reg.epc);
				dq_pkg::SLOT_READ: s_next.tag = sat_inc(s_reg.tag);
				default: s_next = s_reg;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rn16_cnt = s_reg.rn;
	assign epc_cnt = s_reg.epc;
	assign tag_cnt = s_reg.tag;
endmodule
`default_nettype wire

// File: src/dq_ctrl.sv
// Dynamic-Q inventory controller: Q steering, air commands, registers
//
// Summary of operation
// - Mode two changes Q by QueryAdjust
// - Mode two keeps the round going; a Query is sent when Q is unchanged
// - Mode two shares mode one parameters
// - Threshold mode: one round, one Query
// - At most two-power-Q minus one QueryReps
// - Threshold mode ignores repeat limit
// - Q starts at start, bounded min/max
// - RN16 excess beyond threshold lowers Q
// - Scaled EPC excess beyond threshold raises Q
// - Within threshold Q holds
// - Threshold is Q times multiplier, default one
// - EPC count scaled by EPC/RN16 ratio
// - QueryAdjust on Q change or slots done
// - End at minimum Q with no reads
// - One session held for whole round
// - Mode one: Query plus repeat-limit QueryReps
// - Mode one: high/low factors steer Q
// - Mode one ends on empty Q-zero round
`timescale 1ns/1ps
`default_nettype none
module dq_ctrl #(
	parameter int CW = dq_pkg::CW
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Air command request and acceptance by the modem
	output dq_pkg::dq_cmd_bus_t cmd_out,
	input wire logic cmd_ready,
	// Slot result from the modem
	input wire dq_pkg::dq_res_bus_t res_in,
	// Status
	output logic busy
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ISSUE = 5'b00010,
		ST_WAIT = 5'b00100,
		ST_EVAL = 5'b01000,
		ST_DONE = 5'b10000
	} dq_state_t;

	typedef struct packed {
		dq_state_t st;
		logic [1:0] mode;
		logic [1:0] sess;
		logic [1:0] sess_run;
		logic [3:0] q_start;
		logic [3:0] q_max;
		logic [3:0] q_min;
		logic [3:0] mult;
		logic [3:0] hi_f;
		logic [3:0] lo_f;
		logic [15:0] reps;
		logic [3:0] q;
		dq_pkg::dq_cmd_t cmd;
		logic [2:0] updn;
		logic [16:0] slot;
		logic round_read;
		logic cnt_clr;
		logic [15:0] rdata;
	} dq_st_t;

	dq_st_t s_reg, s_next;
	logic [CW-1:0] rn16_cnt, epc_cnt, tag_cnt;
	logic [CW-1:0] epc_adj;
	logic [CW+3:0] thr;
	logic [CW+3:0] rn_w, epc_w;
	logic [16:0] slots_q;
	logic dec_q, inc_q, hi_hit, lo_hit;
	logic [CW+3:0] hi_prod, lo_prod;
	logic [3:0] q_rnd;
	logic round_end;

	// Result counters live in their own module
	dq_cnt #(.W(CW)) u_cnt (
		.clk(clk),
		.rst_n(rst_n),
		.clear(s_reg.cnt_clr),
		.valid(res_in.valid),
		.res(res_in.res),
		.rn16_cnt(rn16_cnt),
		.epc_cnt(epc_cnt),
		.tag_cnt(tag_cnt)
	);

	// Q bump that saturates at the programmed bounds
	function automatic logic [3:0] q_step(input logic [3:0] q,
		input logic up, input logic [3:0] lo, input logic [3:0] hi);
		if (up) begin
			q_step = (q >= hi) ? hi : q + 4'h1;
		end else begin
			q_step = (q <= lo) ? lo : q - 4'h1;
		end
	endfunction

	// Clamp a programmed start Q into the legal range
	function automatic logic [3:0] q_clamp(input logic [3:0] q,
		input logic [3:0] lo, input logic [3:0] hi);
		if (q > hi) begin
			q_clamp = hi;
		end else if (q < lo) begin
			q_clamp = lo;
		end else begin
			q_clamp = q;
		end
	endfunction

	// Threshold arithmetic. Scaling EPC by EPC/RN16 gives EPC*EPC/RN16;
	// a divider would be large, so compare by cross-multiplying instead.
	always_comb begin
		epc_adj = epc_cnt;
		rn_w = {4'h0, rn16_cnt};
		epc_w = {4'h0, epc_adj};
		thr = {{(CW-4){1'b0}}, {4'h0, s_reg.q} * {4'h0, s_reg.mult}};
		slots_q = 17'h1 << s_reg.q;
		dec_q = 1'b0;
		inc_q = 1'b0;
		if (rn16_cnt == '0) begin
			// Ratio taken as one while no RN16 timeout was seen
			dec_q = 1'b0;
			inc_q = epc_w > thr;
		end else begin
			// epc*epc > rn*(rn+thr) means scaled EPC exceeds RN16 + thr
			// rn*rn > epc*epc + rn*thr means RN16 exceeds scaled EPC + thr
			dec_q = (rn_w * rn_w) > (epc_w * epc_w) + rn_w * thr;
			inc_q = (epc_w * epc_w) > rn_w * (rn_w + thr);
		end
		hi_prod = epc_w * {{CW{1'b0}}, s_reg.hi_f};
		lo_prod = epc_w * {{CW{1'b0}}, s_reg.lo_f};
		hi_hit = rn_w > hi_prod;
		lo_hit = rn_w < lo_prod;
		// Next round's Q; high wins if both factors fire
		q_rnd = hi_hit ? q_step(s_reg.q, 1'b0, s_reg.q_min, s_reg.q_max) :
			lo_hit ? q_step(s_reg.q, 1'b1, s_reg.q_min, s_reg.q_max) :
			s_reg.q;
	end

	// Round ends at repeat limit (mode one/two) or slot count (mode three)
	always_comb begin
		if (s_reg.mode == dq_pkg::M_DQ3) begin
			round_end = s_reg.slot >= slots_q - 17'h1;
		end else begin
			round_end = s_reg.slot >= {1'b0, s_reg.reps};
		end
	end

	// Next-state logic: registers, sequencer and Q adjustment
	always_comb begin
		s_next = s_reg;
		s_next.cnt_clr = 1'b0;
		s_next.rdata = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				dq_pkg::A_CTRL: s_next.rdata = {10'h000, s_reg.sess,
					1'b0, s_reg.mode, busy};
				dq_pkg::A_QCFG: s_next.rdata = {s_reg.mult, s_reg.q_min,
					s_reg.q_max, s_reg.q_start};
				dq_pkg::A_THR: s_next.rdata = {8'h00, s_reg.hi_f, s_reg.lo_f};
				dq_pkg::A_REPS: s_next.rdata = s_reg.reps;
				dq_pkg::A_STAT: s_next.rdata = {7'h00, s_reg.st, s_reg.q};
				dq_pkg::A_RN16: s_next.rdata = rn16_cnt[15:0];
				dq_pkg::A_EPC: s_next.rdata = epc_cnt[15:0];
				dq_pkg::A_TAGS: s_next.rdata = tag_cnt[15:0];
				default: s_next.rdata = 16'h0000;
			endcase
		end
		// Configuration writes apply at the next clock edge, also while busy
		if (reg_wr) begin
			unique case (reg_addr)
				dq_pkg::A_CTRL: begin
					s_next.mode = reg_wdata[dq_pkg::F_MODE +: 2];
					s_next.sess = reg_wdata[dq_pkg::F_SESS +: 2];
				end
				dq_pkg::A_QCFG: begin
					s_next.q_start = reg_wdata[3:0];
					s_next.q_max = reg_wdata[7:4];
					s_next.q_min = reg_wdata[11:8];
					s_next.mult = reg_wdata[15:12];
				end
				dq_pkg::A_THR: begin
					s_next.lo_f = reg_wdata[3:0];
					s_next.hi_f = reg_wdata[7:4];
				end
				dq_pkg::A_REPS: s_next.reps = reg_wdata;
				default: s_next.reps = s_reg.reps;
			endcase
		end
		unique case (s_reg.st)
			ST_IDLE: begin
				if (reg_wr && reg_addr == dq_pkg::A_CTRL &&
					reg_wdata[dq_pkg::F_START] &&
					reg_wdata[dq_pkg::F_MODE +: 2] != 2'h0) begin
					s_next.q = q_clamp(s_reg.q_start, s_reg.q_min,
						s_reg.q_max);
					s_next.sess_run = reg_wdata[dq_pkg::F_SESS +: 2];
					s_next.cmd = dq_pkg::CMD_QUERY;
					s_next.updn = 3'h0;
					s_next.slot = 17'h0;
					s_next.round_read = 1'b0;
					s_next.cnt_clr = 1'b1;
					s_next.st = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (cmd_ready) begin
					s_next.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (res_in.valid) begin
					if (res_in.res == dq_dq_read()) begin
						s_next.round_read = 1'b1;
					end
					s_next.st = ST_EVAL;
				end
			end
			ST_EVAL: begin
				s_next.st = ST_ISSUE;
				s_next.slot = s_reg.slot + 17'h1;
				s_next.cmd = dq_pkg::CMD_REP;
				s_next.updn = 3'h0;
				if (s_reg.mode == dq_pkg::M_DQ3) begin
					// Continuous evaluation after every slot
					if ((dec_q && s_reg.q != s_reg.q_min) ||
						(inc_q && s_reg.q != s_reg.q_max)) begin
						s_next.q = q_step(s_reg.q, inc_q, s_reg.q_min,
							s_reg.q_max);
						s_next.updn = inc_q ? 3'h6 : 3'h3;
						s_next.cmd = dq_pkg::CMD_ADJ;
						s_next.slot = 17'h0;
						s_next.cnt_clr = 1'b1;
					end else if (round_end) begin
						if (s_reg.q == s_reg.q_min && !s_reg.round_read) begin
							s_next.st = ST_DONE;
						end else begin
							s_next.cmd = dq_pkg::CMD_ADJ;
							s_next.updn = 3'h0;
							s_next.slot = 17'h0;
							s_next.round_read = 1'b0;
						end
					end
				end else if (round_end) begin
					// Modes one and two evaluate at the round's end
					if (s_reg.q == 4'h0 && !s_reg.round_read) begin
						s_next.st = ST_DONE;
					end else begin
						s_next.q = q_rnd;
						s_next.slot = 17'h0;
						s_next.round_read = 1'b0;
						s_next.cnt_clr = 1'b1;
						// A saturated Q is no change, so no Adjust is sent
						if (s_reg.mode == dq_pkg::M_DQ2 &&
							q_rnd != s_reg.q) begin
							s_next.cmd = dq_pkg::CMD_ADJ;
							s_next.updn = (q_rnd > s_reg.q) ? 3'h6 : 3'h3;
						end else begin
							s_next.cmd = dq_pkg::CMD_QUERY;
						end
					end
				end
			end
			ST_DONE: begin
				s_next.st = ST_IDLE;
			end
			default: s_next.st = ST_IDLE;
		endcase
	end

	// Single state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= '{st: ST_IDLE, mode: dq_pkg::M_DQ3,
				sess: 2'h0, sess_run: 2'h0,
				q_start: dq_pkg::Q_START_RST, q_max: dq_pkg::Q_MAX_RST,
				q_min: dq_pkg::Q_MIN_RST, mult: dq_pkg::MULT_RST,
				hi_f: dq_pkg::HI_RST, lo_f: dq_pkg::LO_RST,
				reps: dq_pkg::REPS_RST, q: dq_pkg::Q_START_RST,
				cmd: dq_pkg::CMD_QUERY, updn: 3'h0, slot: 17'h0,
				round_read: 1'b0, cnt_clr: 1'b0, rdata: 16'h0000};
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs: request valid is a handshake, data come from registers
	assign busy = s_reg.st != ST_IDLE;
	assign reg_rdata = s_reg.rdata;
	assign cmd_out.valid = s_reg.st == ST_ISSUE;
	assign cmd_out.cmd = s_reg.cmd;
	assign cmd_out.q = s_reg.q;
	assign cmd_out.session = s_reg.sess_run;
	assign cmd_out.updn = s_reg.updn;

	// Read result code, kept as a function for clarity of the compare
	function automatic dq_pkg::dq_res_t dq_dq_read();
		dq_dq_read = dq_pkg::SLOT_READ;
	endfunction
endmodule
`default_nettype wire

// File: testbench/dq_ctrl_asserts.sv
// Port checker for the dynamic-Q inventory controller
`timescale 1ns/1ps
`default_nettype none
module dq_ctrl_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Command link and status
	input wire dq_pkg::dq_cmd_bus_t cmd_out,
	input wire logic cmd_ready,
	input wire dq_pkg::dq_res_bus_t res_in,
	input wire logic busy
);
	logic [3:0] last_q_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Q of the last accepted command, so each Adjust can be judged
	always_ff @(posedge clk) begin
		if (!rst_n)
			last_q_reg <= 4'h0;
		else if (cmd_out.valid && cmd_ready)
			last_q_reg <= cmd_out.q;
	end
	sequence s_take;
		cmd_out.valid && cmd_ready;
	endsequence
	sequence s_wait;
		!cmd_out.valid [*2];
	endsequence
	property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	property p_take_wait; s_take |=> s_wait; endproperty
	a_take_wait: assert property (p_take_wait)
		else $error("command issued before slot result");
	property p_res_gap;
		res_in.valid && !cmd_out.valid |=> !cmd_out.valid;
	endproperty
	a_res_gap: assert property (p_res_gap)
		else $error("command right after result");
	property p_hold;
		cmd_out.valid && !cmd_ready |=> cmd_out.valid && $stable(cmd_out);
	endproperty
	a_hold: assert property (p_hold)
		else $error("command changed before acceptance");
	property p_sess;
		busy && $past(busy) |-> $stable(cmd_out.session);
	endproperty
	a_sess: assert property (p_sess)
		else $error("session changed within a cycle");
	property p_start;
		$rose(busy) |-> cmd_out.valid && cmd_out.cmd == dq_pkg::CMD_QUERY;
	endproperty
	a_start: assert property (p_start)
		else $error("cycle did not open with a Query");
	property p_qstep;
		busy && $past(busy) && $changed(cmd_out.q) |->
			cmd_out.q == $past(cmd_out.q) + 4'h1 ||
			cmd_out.q == $past(cmd_out.q) - 4'h1;
	endproperty
	a_qstep: assert property (p_qstep)
		else $error("Q moved by more than one");
	property p_adj;
		cmd_out.valid && cmd_out.cmd == dq_pkg::CMD_ADJ |->
			(cmd_out.updn == 3'h6 && cmd_out.q == last_q_reg + 4'h1) ||
			(cmd_out.updn == 3'h3 && cmd_out.q == last_q_reg - 4'h1) ||
			(cmd_out.updn == 3'h0 && cmd_out.q == last_q_reg);
	endproperty
	a_adj: assert property (p_adj)
		else $error("Adjust code disagrees with Q");
	property p_idle; !busy |-> !cmd_out.valid; endproperty
	a_idle: assert property (p_idle)
		else $error("command while idle");
endmodule
bind dq_ctrl dq_ctrl_asserts i_dq_ctrl_asserts (.clk(clk), .rst_n(rst_n),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_out(cmd_out),
	.cmd_ready(cmd_ready), .res_in(res_in), .busy(busy));
`default_nettype wire

// File: testbench/dq_tag_model.sv
// Behavioural tag population answering the controller's air commands
`timescale 1ns/1ps
`default_nettype none
module dq_tag_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command link
	input wire dq_pkg::dq_cmd_bus_t cmd,
	output logic cmd_ready,
	output dq_pkg::dq_res_bus_t res,
	// Slot outcome and pace chosen by the bench
	input wire dq_pkg::dq_res_t kind,
	input wire logic slow
);
	logic [3:0] inv_flag;
	logic [2:0] dly;
	logic wait_m;
	logic tick;
	// One slot per accepted command; idle result lines keep toggling
	always_ff @(posedge clk) begin
		cmd_ready <= 1'b0;
		res.valid <= 1'b0;
		res.res <= dq_pkg::dq_res_t'(~res.res);
		tick <= ~tick;
		if (!rst_n) begin
			res <= '0;
			wait_m <= 1'b0;
			dly <= 3'h0;
			inv_flag <= 4'h0;
			tick <= 1'b0;
		end else if (wait_m) begin
			dly <= dly - 3'h1;
			if (dly == 3'h0) begin
				res.valid <= 1'b1;
				res.res <= kind;
				wait_m <= 1'b0;
				// A read tag flips only the flag of this session
				if (kind == dq_pkg::SLOT_READ)
					inv_flag[cmd.session] <= ~inv_flag[cmd.session];
			end
		end else if (cmd.valid && cmd_ready) begin
			wait_m <= 1'b1;
			dly <= slow ? 3'h4 : 3'h0;
		end else if (cmd.valid && (!slow || tick))
			cmd_ready <= 1'b1;
	end
endmodule
`default_nettype wire

// File: testbench/tb_dq_ctrl.sv
// Self-checking bench for the dynamic-Q inventory controller
`timescale 1ns/1ps
`default_nettype none
module tb_dq_ctrl;
	typedef struct packed {logic w; logic [3:0] a; logic [15:0] d;} dq_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic cmd_ready;
	logic busy;
	dq_pkg::dq_cmd_bus_t cmd_out;
	dq_pkg::dq_res_bus_t res_in;
	dq_pkg::dq_res_t kind = dq_pkg::SLOT_EMPTY;
	logic slow = 1'b0;
	logic [1:0] sess = 2'h0;
	logic [8:0] log_q[$];
	int miscompares = 0;
	int checks = 0;
	// Register rows: write flag, address, data or expected read value
	dq_row_t rows[14] = '{{1'b0, 4'h0, 16'h0006},
		{1'b0, 4'h1, 16'h10F4}, {1'b0, 4'h2, 16'h0021},
		{1'b0, 4'h3, 16'h0010}, {1'b0, 4'h4, 16'h0014},
		{1'b0, 4'h7, 16'h0000}, {1'b1, 4'h2, 16'h0053},
		{1'b0, 4'h2, 16'h0053}, {1'b1, 4'h8, 16'hFFFF},
		{1'b0, 4'h8, 16'h0000}, {1'b1, 4'h5, 16'h1234},
		{1'b0, 4'h5, 16'h0000}, {1'b1, 4'h3, 16'h0002},
		{1'b0, 4'h3, 16'h0002}};
	dq_ctrl i_dq_ctrl (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .cmd_out, .cmd_ready, .res_in, .busy);
	dq_tag_model i_dq_tag_model (.clk, .rst_n, .cmd(cmd_out), .cmd_ready,
		.res(res_in), .kind, .slow);
	always #25 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(reg_rdata, exp);
	endtask
	task automatic wait_cmds(input int n);
		for (int i = 0; i < 3000 && log_q.size() < n; i++)
			@(posedge clk);
		check(16'(log_q.size()), 16'(n));
	endtask
	task automatic wait_idle();
		@(negedge clk);
		for (int i = 0; i < 3000 && busy !== 1'b0; i++)
			@(negedge clk);
		check(16'(busy), 16'h0000);
	endtask
	task automatic start(input logic [15:0] ctrl);
		log_q.delete();
		wr(dq_pkg::A_CTRL, ctrl);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// Log every accepted command; the session must match the programmed one
	always @(posedge clk) begin
		if (rst_n && cmd_out.valid && cmd_ready) begin
			log_q.push_back({cmd_out.cmd, cmd_out.q,
				cmd_out.cmd == dq_pkg::CMD_ADJ ? cmd_out.updn : 3'h0});
			check(16'(cmd_out.session), 16'(sess));
		end
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			else
				rd(rows[i].a, rows[i].d);
		end
		done("registers");
		// Modes one and two at Q zero: Query plus two Reps, then the end
		wr(dq_pkg::A_QCFG, 16'h10F0);
		for (int m = 1; m <= 2; m++) begin
			start(16'(m * 2 + 1));
			wait_idle();
			check(16'(log_q.size()), 16'h0003);
			check(16'(log_q[2]), {7'h0, dq_pkg::CMD_REP, 7'h00});
		end
		done("modes one and two");
		// Empty slots: Q drops once empties exceed Q, sweeps down to the end
		wr(dq_pkg::A_QCFG, 16'h10F4);
		sess = 2'h1;
		start(16'h0017);
		wait_cmds(6);
		check(16'(log_q[0]), {7'h0, dq_pkg::CMD_QUERY, 4'h4, 3'h0});
		check(16'(log_q[4]), {7'h0, dq_pkg::CMD_REP, 4'h4, 3'h0});
		check(16'(log_q[5]), {7'h0, dq_pkg::CMD_ADJ, 4'h3, 3'h3});
		wait_idle();
		rd(dq_pkg::A_STAT, 16'h0010);
		done("empty slots");
		// Collisions against a slow far side, then a reset in mid-run
		kind <= dq_pkg::SLOT_COLL;
		slow <= 1'b1;
		sess = 2'h2;
		start(16'h0027);
		wait_cmds(6);
		check(16'(log_q[5]), {7'h0, dq_pkg::CMD_ADJ, 4'h5, 3'h6});
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(16'({busy, cmd_out.valid}), 16'h0000);
		rd(dq_pkg::A_QCFG, 16'h10F4);
		rd(dq_pkg::A_STAT, 16'h0014);
		done("collisions and reset");
		// Q pinned at two with a wide threshold: Reps past the limit, Adjust
		kind <= dq_pkg::SLOT_READ;
		slow <= 1'b0;
		sess = 2'h3;
		wr(dq_pkg::A_QCFG, 16'hF222);
		wr(dq_pkg::A_REPS, 16'h0001);
		start(16'h0037);
		wait_cmds(5);
		check(16'(log_q[3]), {7'h0, dq_pkg::CMD_REP, 4'h2, 3'h0});
		check(16'(log_q[4]), {7'h0, dq_pkg::CMD_ADJ, 4'h2, 3'h0});
		kind <= dq_pkg::SLOT_EMPTY;
		wait_idle();
		rd(dq_pkg::A_STAT, 16'h0012);
		done("held Q");
		stop_test();
	end
	// Watchdog: the whole run needs far fewer than 20000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		stop_test();
	end
endmodule
`default_nettype wire
